// ===== vfds_pkg.sv
package vfds_pkg;
  // Clock and bus
  localparam int unsigned VFDS_CLK_HZ = 125_000_000;
  localparam int unsigned VFDS_TW = 27;
  typedef logic [VFDS_TW-1:0] vfds_cnt_t;
  // Times in their own units
  localparam int unsigned VFDS_SHDN_MS = 25;
  localparam int unsigned VFDS_UNPLUG_US = 20;
  localparam int unsigned VFDS_TRANS_MS = 600;
  localparam int unsigned VFDS_DISCH_MS = 650;
  localparam int unsigned VFDS_HOLD_MS = 765;
  // Cycle counts: least times round up, longest times round down
  localparam int unsigned VFDS_SHDN_CYC = VFDS_SHDN_MS * (VFDS_CLK_HZ / 1000);
  // Unplug count leaves room for the timer load and expiry cycles
  localparam int unsigned VFDS_UNPLUG_CYC = VFDS_UNPLUG_US * (VFDS_CLK_HZ / 1_000_000) - 3;
  localparam int unsigned VFDS_TRANS_CYC = VFDS_TRANS_MS * (VFDS_CLK_HZ / 1000);
  localparam int unsigned VFDS_DISCH_CYC = VFDS_DISCH_MS * (VFDS_CLK_HZ / 1000);
  localparam int unsigned VFDS_HOLD_CYC = VFDS_HOLD_MS * (VFDS_CLK_HZ / 1000);
  // Register map
  localparam logic [11:0] VFDS_CTRL_OFS = 12'h000;
  localparam logic [11:0] VFDS_STAT_OFS = 12'h004;
  localparam int unsigned VFDS_CTRL_EN_BIT = 0;
  localparam int unsigned VFDS_CTRL_CLR_BIT = 1;
  localparam logic VFDS_CTRL_EN_RST = 1'b1;
  localparam int unsigned VFDS_STAT_HIGH_POWER_SELECT_BIT = 4;
  localparam int unsigned VFDS_STAT_FAST_BIT = 5;
  localparam int unsigned VFDS_STAT_PDS_BIT = 6;
  localparam int unsigned VFDS_STAT_CNT_LSB = 8;
  // Supply-select code for 5 V
  localparam logic [2:0] VFDS_CTL_5V = 3'h0;
  // Sequencer states
  typedef enum logic [3:0] {
    VFDS_IDLE, VFDS_BLEED, VFDS_SOURCE, VFDS_SHDN, VFDS_DISCH_HI,
    VFDS_DISCH_LO, VFDS_FAST, VFDS_HOLD
  } vfds_state_t;
endpackage

// ===== vfds_tmr_if.sv
`timescale 1ns/100ps
`default_nettype none
interface vfds_tmr_if;
  import vfds_pkg::*;
  logic load;
  vfds_cnt_t value;
  logic expired;
  modport ctl (output load, output value, input expired);
  modport tmr (input load, input value, output expired);
endinterface
`default_nettype wire

// ===== vfds_timer.sv
`timescale 1ns/100ps
`default_nettype none
module vfds_timer import vfds_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  vfds_tmr_if.tmr t
);
  typedef struct packed {
    vfds_cnt_t cnt;
    logic run;
    logic exp;
  } vfds_tmr_st_t;
  vfds_tmr_st_t q, d;

  // Count down; a new load restarts
  always_comb begin
    d = q;
    d.exp = 1'b0;
    if (t.load) begin
      d.cnt = t.value;
      d.run = 1'b1;
    end else if (q.run) begin
      if (q.cnt <= vfds_cnt_t'(1)) begin
        d.run = 1'b0;
        d.exp = 1'b1;
      end else begin
        d.cnt = q.cnt - vfds_cnt_t'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign t.expired = q.exp;
endmodule // vfds_timer
`default_nettype wire

// ===== vfds_sequencer.sv
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module vfds_sequencer import vfds_pkg::*; #(
  parameter int unsigned SHDN_CYC = VFDS_SHDN_CYC,
  parameter int unsigned TRANS_CYC = VFDS_TRANS_CYC,
  parameter int unsigned DISCH_CYC = VFDS_DISCH_CYC,
  parameter int unsigned HOLD_CYC = VFDS_HOLD_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic sink_attached_in,
  input wire logic contract_done_in,
  input wire logic unplug_in,
  input wire logic hard_reset_rx_in,
  input wire logic thermal_shutdown_in,
  input wire logic low_alarm_in,
  input wire logic high_alarm_in,
  input wire logic unexpected_msg_in,
  input wire logic soft_reset_fail_in,
  input wire logic request_timeout_in,
  input wire logic transition_start_in,
  input wire logic transition_done_in,
  input wire logic overvoltage_protection_in,
  input wire logic overcurrent_protection_in,
  input wire logic vbus_fall_threshold_in,
  input wire logic pd_msg_sent_in,
  input wire logic gate_disable_input_in,
  input wire logic supply_sense_ok_in,
  input wire logic supply_above_fovp_in,
  input wire logic vbus_below_sovp5_in,
  input wire logic vbus_discharged_in,
  input wire logic [2:0] contract_select_in,
  input wire logic high_power_select_in,
  input wire logic power_halving_input_in,
  output logic gate_drive_output_out,
  output logic discharge_bleed_out,
  output logic discharge_full_out,
  output logic supply_bleed_out,
  output logic supply_select_line_1_out,
  output logic supply_select_line_2_out,
  output logic supply_select_line_3_out,
  output logic hard_reset_tx_out,
  output logic resend_caps_out,
  output logic voltage_set_alt_out
);
  typedef struct packed {
    vfds_state_t st;
    logic gate;
    logic bleed;
    logic full;
    logic sbleed;
    logic [2:0] ctl;
    logic hr_tx;
    logic resend;
    logic high_power_select;
    logic sampled;
    logic halve_prev;
    logic gd_prev;
    logic pd_started;
    logic in_trans;
    logic fast_cls;
    logic en;
    logic [7:0] faults;
    logic ld;
    vfds_cnt_t val;
    logic [31:0] rdata;
  } vfds_seq_st_t;
  vfds_seq_st_t q, d;

  vfds_tmr_if tif ();

  vfds_timer u_timer (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .t (tif.tmr)
  );

  assign tif.load = q.ld;
  assign tif.value = q.val;

  // Register address decode
  function automatic logic [1:0] vfds_dec(input logic [11:0] a);
    vfds_dec = {a == VFDS_STAT_OFS, a == VFDS_CTRL_OFS};
  endfunction
  logic [1:0] adec;
  assign adec = vfds_dec(paddr_in);

  // Fault classification
  logic gd_fall, fast_f, slow_hr_f, tmo;
  assign gd_fall = q.gd_prev & ~gate_disable_input_in;
  assign tmo = tif.expired;
  always_comb begin
    fast_f = overvoltage_protection_in | gd_fall;
    fast_f = fast_f | (q.pd_started & (overcurrent_protection_in
      | vbus_fall_threshold_in));
    slow_hr_f = thermal_shutdown_in | soft_reset_fail_in | request_timeout_in;
    slow_hr_f = slow_hr_f | (~q.in_trans & (low_alarm_in | high_alarm_in));
    slow_hr_f = slow_hr_f | (q.in_trans & unexpected_msg_in);
    slow_hr_f = slow_hr_f | (q.in_trans & tmo);
  end

  // Sequencer, side flags and APB
  always_comb begin
    d = q;
    d.hr_tx = 1'b0;
    d.resend = 1'b0;
    d.ld = 1'b0;
    d.gd_prev = gate_disable_input_in;
    // Latch high-power select once
    if (!q.sampled) begin
      d.high_power_select = high_power_select_in;
      d.sampled = 1'b1;
    end
    // Capability refresh on halving change
    d.halve_prev = power_halving_input_in;
    if (power_halving_input_in != q.halve_prev) begin
      d.resend = 1'b1;
    end
    // Transition tracking
    if (transition_done_in) begin
      d.in_trans = 1'b0;
    end
    if (q.st == VFDS_SOURCE && transition_start_in) begin
      d.in_trans = 1'b1;
      d.ld = 1'b1;
      d.val = vfds_cnt_t'(TRANS_CYC);
    end
    case (q.st)
      VFDS_IDLE: begin
        d.gate = 1'b0;
        d.full = 1'b0;
        d.bleed = 1'b0;
        d.sbleed = 1'b0;
        d.ctl = VFDS_CTL_5V;
        d.pd_started = 1'b0;
        d.in_trans = 1'b0;
        if (sink_attached_in && q.en) begin
          d.st = VFDS_BLEED;
          d.bleed = 1'b1;
          d.sbleed = 1'b1;
        end
      end
      VFDS_BLEED: begin
        if (supply_sense_ok_in) begin
          d.gate = 1'b1;
        end
        if (contract_done_in && q.gate) begin
          d.st = VFDS_SOURCE;
          d.bleed = 1'b0;
          d.sbleed = 1'b0;
        end
      end
      VFDS_SOURCE: begin
        d.ctl = contract_select_in;
      end
      VFDS_SHDN: begin
        if (tmo) begin
          d.st = VFDS_DISCH_HI;
          d.ctl = VFDS_CTL_5V;
          d.full = 1'b1;
          d.ld = 1'b1;
          d.val = vfds_cnt_t'(DISCH_CYC);
        end
      end
      VFDS_DISCH_HI: begin
        if (tmo) begin
          d.hr_tx = 1'b1;
          d.ld = 1'b1;
          d.val = vfds_cnt_t'(DISCH_CYC);
        end else if (vbus_below_sovp5_in) begin
          d.st = VFDS_DISCH_LO;
          d.gate = 1'b0;
        end
      end
      VFDS_DISCH_LO: begin
        if (tmo) begin
          d.st = VFDS_DISCH_HI;
          d.hr_tx = 1'b1;
          d.ld = 1'b1;
          d.val = vfds_cnt_t'(DISCH_CYC);
        end else if (vbus_discharged_in) begin
          d.st = VFDS_HOLD;
          d.full = 1'b0;
          d.ld = 1'b1;
          d.val = vfds_cnt_t'(HOLD_CYC);
        end
      end
      VFDS_FAST: begin
        if (tmo) begin
          d.st = VFDS_SHDN;
          d.hr_tx = 1'b1;
          d.fast_cls = 1'b0;
          d.ld = 1'b1;
          d.val = vfds_cnt_t'(SHDN_CYC);
        end else if (vbus_discharged_in) begin
          d.st = VFDS_HOLD;
          d.full = 1'b0;
          d.ld = 1'b1;
          d.val = vfds_cnt_t'(HOLD_CYC);
        end
      end
      VFDS_HOLD: begin
        if (tmo) begin
          if (q.fast_cls && supply_above_fovp_in) begin
            d.st = VFDS_FAST;
            d.hr_tx = 1'b1;
            d.full = 1'b1;
            d.ld = 1'b1;
            d.val = vfds_cnt_t'(DISCH_CYC);
          end else begin
            d.st = VFDS_IDLE;
            d.bleed = 1'b0;
            d.sbleed = 1'b0;
          end
        end
      end
      default: begin
        d.st = VFDS_IDLE;
      end
    endcase
    // Slow faults while attached
    if (q.st == VFDS_BLEED || q.st == VFDS_SOURCE) begin
      if (unplug_in || hard_reset_rx_in || slow_hr_f) begin
        d.st = VFDS_SHDN;
        d.bleed = 1'b1;
        d.sbleed = 1'b1;
        d.fast_cls = 1'b0;
        d.in_trans = 1'b0;
        d.hr_tx = slow_hr_f & ~unplug_in & ~hard_reset_rx_in;
        d.ld = 1'b1;
        d.val = unplug_in ? vfds_cnt_t'(VFDS_UNPLUG_CYC)
          : vfds_cnt_t'(SHDN_CYC);
      end
    end
    // Fast faults override everything but idle and fast discharge
    if (q.st != VFDS_IDLE && q.st != VFDS_FAST && fast_f) begin
      d.st = VFDS_FAST;
      d.gate = 1'b0;
      d.full = 1'b1;
      d.bleed = 1'b1;
      d.sbleed = 1'b1;
      d.hr_tx = 1'b1;
      d.fast_cls = 1'b1;
      d.in_trans = 1'b0;
      d.ld = 1'b1;
      d.val = vfds_cnt_t'(DISCH_CYC);
    end
    // Shutdown counter, increment beats clear
    if (psel_in && penable_in && pwrite_in && adec[0]) begin
      d.en = pwdata_in[VFDS_CTRL_EN_BIT];
      if (pwdata_in[VFDS_CTRL_CLR_BIT]) begin
        d.faults = 8'h00;
      end
    end
    if ((d.st == VFDS_SHDN || d.st == VFDS_FAST) && d.st != q.st && q.faults != 8'hFF) begin
      d.faults = q.faults + 8'h01;
    end
    // PD activity flag, set only outside idle; idle clears it
    if (pd_msg_sent_in && q.st != VFDS_IDLE) begin
      d.pd_started = 1'b1;
    end
    // Read data captured in setup phase
    if (psel_in && !penable_in) begin
      d.rdata = 32'h0;
      if (adec[0]) begin
        d.rdata[VFDS_CTRL_EN_BIT] = q.en;
      end else if (adec[1]) begin
        d.rdata[3:0] = q.st;
        d.rdata[VFDS_STAT_HIGH_POWER_SELECT_BIT] = q.high_power_select;
        d.rdata[VFDS_STAT_FAST_BIT] = q.fast_cls;
        d.rdata[VFDS_STAT_PDS_BIT] = q.pd_started;
        d.rdata[VFDS_STAT_CNT_LSB +: 8] = q.faults;
      end
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
      q.st <= VFDS_IDLE;
      q.ctl <= VFDS_CTL_5V;
      q.en <= VFDS_CTRL_EN_RST;
      q.gd_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & (vfds_dec(paddr_in) == 2'b00);
  assign prdata_out = q.rdata;
  assign gate_drive_output_out = q.gate;
  assign discharge_bleed_out = q.bleed;
  assign discharge_full_out = q.full;
  assign supply_bleed_out = q.sbleed;
  assign {supply_select_line_3_out, supply_select_line_2_out, supply_select_line_1_out} = q.ctl;
  assign hard_reset_tx_out = q.hr_tx;
  assign resend_caps_out = q.resend;
  assign voltage_set_alt_out = q.high_power_select;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_fast_hit;
    q.st != VFDS_IDLE && q.st != VFDS_FAST && fast_f;
  endsequence
  sequence s_fast_done;
    !gate_drive_output_out && discharge_full_out && hard_reset_tx_out;
  endsequence

  a_gate_after_check: assert property ($rose(gate_drive_output_out) && q.st == VFDS_BLEED
    |-> $past(supply_sense_ok_in)) else $error("gate rose without supply check");
  a_bleed_before_contract: assert property (q.st == VFDS_BLEED
    |-> discharge_bleed_out && supply_bleed_out) else $error("no bleed before contract");
  a_fast_gate_drop: assert property (s_fast_hit |=> s_fast_done)
    else $error("fast fault not handled next cycle");
  a_slow_gate_holds: assert property (q.st == VFDS_SHDN && $past(q.st) == VFDS_SOURCE
    |-> gate_drive_output_out && supply_bleed_out) else $error("gate lost in delay");
  a_hr_at_start: assert property ((q.st == VFDS_BLEED || q.st == VFDS_SOURCE) && !fast_f
    && slow_hr_f && !unplug_in && !hard_reset_rx_in |=> hard_reset_tx_out && q.st == VFDS_SHDN)
    else $error("hard reset not sent at delay start");
  a_no_hr_on_rx: assert property (q.st == VFDS_SOURCE && hard_reset_rx_in && !fast_f
    |=> !hard_reset_tx_out) else $error("hard reset sent on received reset");
  a_five_volt_disch: assert property (q.st == VFDS_DISCH_HI |-> discharge_full_out
    && q.ctl == VFDS_CTL_5V) else $error("bad high discharge outputs");
  a_low_disch_gate: assert property (q.st == VFDS_DISCH_LO |-> !gate_drive_output_out
    && discharge_full_out) else $error("gate on in low discharge");
  a_resend_caps: assert property ($changed(power_halving_input_in) |=> resend_caps_out)
    else $error("caps not resent");
  a_high_power_select_latched: assert property (q.sampled |=> $stable(voltage_set_alt_out))
    else $error("high power latch moved");
  a_ocp_masked: assert property (q.st == VFDS_SOURCE && !q.pd_started && !overvoltage_protection_in
    && !gd_fall |=> gate_drive_output_out) else $error("overcurrent acted too early");
endmodule // vfds_sequencer
`default_nettype wire

// ===== vfds_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module vfds_far_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic gate_in,
  input wire logic full_in,
  input wire logic stall_in,
  output logic below_sovp5_out,
  output logic discharged_out
);
  logic [5:0] lvl_q;
  // Coarse VBUS level: high while sourcing, falls one step per cycle under full discharge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lvl_q <= 6'h00;
    end else if (gate_in && !full_in) begin
      lvl_q <= 6'h28;
    end else if (full_in && !stall_in && lvl_q != 6'h00) begin
      lvl_q <= lvl_q - 6'h01; // Stall models a load that defeats discharge
    end
  end
  // Comparator outputs seen by the sequencer
  assign below_sovp5_out = (lvl_q < 6'h14);
  assign discharged_out = (lvl_q < 6'h04);
endmodule // vfds_far_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import vfds_pkg::*;
  localparam int unsigned SHDN = 20;
  localparam int unsigned TRANS = 40;
  localparam int unsigned DISCH = 60;
  localparam int unsigned HOLD = 30;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, gate, bleed, full, sbleed, s1, s2, s3, hrtx, resend, alt, below, dis;
  logic sink = 1'b0, sense = 1'b0, fovp = 1'b0, hps = 1'b1, halve = 1'b0, gdis = 1'b1;
  logic stall = 1'b0;
  logic [2:0] csel = 3'h5;
  // Events: 0 unplug 1 hr_rx 2 therm 3 low 4 high 5 unexp 6 srf 7 reqto 8 tstart
  // 9 tdone 10 ovp 11 ocp 12 vfall 13 pd_sent 14 contract
  logic [14:0] ev = 15'h0000;
  int fail_count = 0;
  int n_tests = 0;
  vfds_sequencer #(.SHDN_CYC(SHDN), .TRANS_CYC(TRANS), .DISCH_CYC(DISCH), .HOLD_CYC(HOLD))
  vfds_sequencer_i (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .sink_attached_in(sink),
    .contract_done_in(ev[14]), .unplug_in(ev[0]), .hard_reset_rx_in(ev[1]),
    .thermal_shutdown_in(ev[2]), .low_alarm_in(ev[3]), .high_alarm_in(ev[4]),
    .unexpected_msg_in(ev[5]), .soft_reset_fail_in(ev[6]), .request_timeout_in(ev[7]),
    .transition_start_in(ev[8]), .transition_done_in(ev[9]),
    .overvoltage_protection_in(ev[10]), .overcurrent_protection_in(ev[11]),
    .vbus_fall_threshold_in(ev[12]), .pd_msg_sent_in(ev[13]), .gate_disable_input_in(gdis),
    .supply_sense_ok_in(sense), .supply_above_fovp_in(fovp), .vbus_below_sovp5_in(below),
    .vbus_discharged_in(dis), .contract_select_in(csel), .high_power_select_in(hps),
    .power_halving_input_in(halve), .gate_drive_output_out(gate), .discharge_bleed_out(bleed),
    .discharge_full_out(full), .supply_bleed_out(sbleed), .supply_select_line_1_out(s1),
    .supply_select_line_2_out(s2), .supply_select_line_3_out(s3), .hard_reset_tx_out(hrtx),
    .resend_caps_out(resend), .voltage_set_alt_out(alt));
  vfds_far_model vfds_far_model_i (.clk_in(clk_in), .rst_in(rst_in), .gate_in(gate),
    .full_in(full), .stall_in(stall), .below_sovp5_out(below), .discharged_out(dis));
  // Clock
  always #4 clk_in = ~clk_in;
  task automatic conclude();
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    if (k >= 20) begin
      fail_count++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return hrtx;
      1: return gate;
      2: return full;
      default: return resend;
    endcase
  endfunction
  // Bounded wait for an output level; hit says whether it should appear
  task automatic waitfor(input int s, input logic v, input int bound, input logic hit,
                         output int n);
    logic seen;
    n = 0;
    #1;
    seen = (sig(s) === v);
    while (!seen && n < bound) begin
      @(posedge clk_in);
      #1;
      n++;
      seen = (sig(s) === v);
    end
    chk({31'h0, seen}, {31'h0, hit});
  endtask
  task automatic fire(input int c);
    @(posedge clk_in);
    ev[c] <= 1'b1;
    @(posedge clk_in);
    ev <= 15'h0000;
  endtask
  // Finish a shutdown, wait for gate to return, finalize a contract
  task automatic recover();
    int n;
    waitfor(1, 1'b0, 400, 1'b1, n);
    waitfor(1, 1'b1, 400, 1'b1, n);
    fire(14);
    repeat (3) @(posedge clk_in);
  endtask
  initial begin
    #800000;
    fail_count++;
    conclude();
  end
  initial begin
    int n;
    logic [31:0] r;
    logic e;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk({27'h0, gate, full, bleed, sbleed, hrtx}, 32'h0);
    apb(1'b0, VFDS_CTRL_OFS, 32'h0, r, e);
    chk(r, 32'h0000_0001);
    apb(1'b0, VFDS_STAT_OFS, 32'h0, r, e);
    chk(r, 32'h0000_0010);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, VFDS_CTRL_OFS, 32'h0, r, e);
    apb(1'b0, VFDS_CTRL_OFS, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b1, VFDS_CTRL_OFS, 32'h1, r, e);
    hps <= 1'b0;
    sink <= 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    chk({28'h0, alt, bleed, sbleed, gate}, 32'hE);
    @(posedge clk_in) sense <= 1'b1;
    waitfor(1, 1'b1, 10, 1'b1, n);
    fire(14);
    repeat (3) @(posedge clk_in);
    #1;
    chk({27'h0, bleed, sbleed, s3, s2, s1}, 32'h5);
    // Slow shutdown walk
    fire(2);
    waitfor(0, 1'b1, 3, 1'b1, n);
    chk({28'h0, gate, bleed, sbleed, full}, 32'hE);
    waitfor(2, 1'b1, SHDN + 5, 1'b1, n);
    chk({27'h0, n >= SHDN, gate, s3, s2, s1}, 32'h18);
    waitfor(1, 1'b0, 40, 1'b1, n);
    chk({30'h0, below, full}, 32'h3);
    waitfor(2, 1'b0, 40, 1'b1, n);
    chk({31'h0, dis}, 32'h1);
    waitfor(1, 1'b1, 300, 1'b1, n);
    chk({31'h0, n >= HOLD}, 32'h1);
    fire(14);
    // Shutdowns that send no Hard Reset
    for (int i = 0; i < 2; i++) begin
      fire(i);
      waitfor(0, 1'b1, 6, 1'b0, n);
      waitfor(2, 1'b1, 2600, 1'b1, n);
      chk({31'h0, (i == 0) ? (n + 6 < 2500) : (n + 6 >= SHDN)}, 32'h1);
      recover();
    end
    // Slow faults that send a Hard Reset
    for (int c = 3; c < 8; c++) begin
      if (c == 5) fire(8);
      fire(c);
      waitfor(0, 1'b1, 3, 1'b1, n);
      recover();
    end
    fire(8);
    fire(9);
    waitfor(0, 1'b1, TRANS + 10, 1'b0, n);
    fire(8);
    waitfor(0, 1'b1, TRANS + 5, 1'b1, n);
    chk({31'h0, n >= TRANS}, 32'h1);
    recover();
    // Stuck discharge: watchdog resends Hard Reset and restarts
    fire(2);
    waitfor(0, 1'b1, 3, 1'b1, n);
    @(posedge clk_in) stall <= 1'b1;
    waitfor(2, 1'b1, SHDN + 5, 1'b1, n);
    waitfor(0, 1'b1, DISCH + 5, 1'b1, n);
    chk({30'h0, n + 3 >= DISCH, full}, 32'h3);
    @(posedge clk_in) stall <= 1'b0;
    recover();
    // Overcurrent ignored before the first PD message
    fire(11);
    waitfor(1, 1'b0, 5, 1'b0, n);
    for (int i = 0; i < 4; i++) begin
      fire(13);
      if (i == 3) begin
        @(posedge clk_in) gdis <= 1'b0;
        @(posedge clk_in) gdis <= 1'b1;
      end else begin
        fire((i == 0) ? 11 : (i == 1) ? 12 : 10);
      end
      waitfor(1, 1'b0, 3, 1'b1, n);
      chk({30'h0, full, hrtx}, 32'h3);
      recover();
    end
    // Supply stays above fast threshold: procedure repeats
    @(posedge clk_in) fovp <= 1'b1;
    fire(10);
    waitfor(0, 1'b1, 3, 1'b1, n);
    waitfor(2, 1'b0, 60, 1'b1, n);
    waitfor(0, 1'b1, HOLD + 5, 1'b1, n);
    @(posedge clk_in) fovp <= 1'b0;
    recover();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in) halve <= ~halve;
      waitfor(3, 1'b1, 4, 1'b1, n);
    end
    // Status: sourcing, latched select, last shutdown fast, 16 shutdowns; then clear
    apb(1'b0, VFDS_STAT_OFS, 32'h0, r, e);
    chk(r, 32'h0000_1032);
    apb(1'b1, VFDS_CTRL_OFS, 32'h3, r, e);
    apb(1'b0, VFDS_STAT_OFS, 32'h0, r, e);
    chk(r, 32'h0000_0032);
    conclude();
  end
endmodule // testbench
`default_nettype wire
